// ===== hw/synth_divider_config.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "synth_defs.svh"

// Function
// - pre reference divide 1 to 128
// - post reference divide 1 to 255
// - integer divide 29 up to 524287
// - 32-bit denominator, 1 to max
// - modulator order 0 to 3
// - detector rate from doubler and dividers
// - doubler uses both reference edges
// - calibration clock is reference over 2^exp
// - divide is integer plus numerator/denominator
// - register zero write resets modulator
// - sync extra divide one outside sync
// - select 0 puts readback on pin
// - detector drives pump until aligned
// - select 1 puts lock on pin
// - trigger write starts band calibration

module synth_divider_config
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // register port
   input wire synth_pkg::bus_req_type i_bus,
   output logic [31:0] o_rd_data,
   // feedback divider edge
   input wire logic i_fb_pulse,
   // detector and modulator
   output logic o_pump_up,
   output logic o_pump_dn,
   output logic [3:0] o_pump_current,
   output logic o_n_strobe,
   output logic [19:0] o_n_value,
   // calibration and pin
   output logic o_cal_tick,
   output logic o_shared_output_pin,
   output logic o_cfg_error
);

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   synth_pkg::cfg_type stage_reg;
   synth_pkg::cfg_type act_reg;
   synth_pkg::cfg_type cand;
   synth_pkg::cal_state_type cal_state_reg;
   logic pin_function_select_reg;
   logic chan_err_reg;
   logic applied_reg;
   logic r0_write;
   logic cand_ok;
   logic [31:0] pfd_count_reg;
   logic [31:0] rb_shift_reg;
   logic lock_reg;

   assign r0_write = i_bus.wr && (i_bus.addr == `REG_CTRL);

   always_comb
   begin
      cand = stage_reg;
      cand.sync_mode = i_bus.wdata[`CTRL_SYNC_MODE];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         stage_reg <= '0;
         stage_reg.pre_div <= `RST_DIV;
         stage_reg.post_div <= `RST_DIV;
         stage_reg.n_int <= `RST_N_INT;
         stage_reg.frac_denominator <= `RST_FRAC_DENOMINATOR;
         stage_reg.dly <= `RST_DLY;
         stage_reg.sync_div <= `RST_DIV;
         stage_reg.chan_div <= `RST_DIV;
         stage_reg.pump <= `RST_PUMP;
      end
      else if (i_bus.wr)
      begin
         if (i_bus.addr == `REG_REFCFG)
         begin
            stage_reg.doubler <= i_bus.wdata[0];
            stage_reg.pre_div <= i_bus.wdata[15:8];
            stage_reg.post_div <= i_bus.wdata[23:16];
            stage_reg.cal_exp <= i_bus.wdata[26:24];
         end
         else if (i_bus.addr == `REG_NINT)
            stage_reg.n_int <= i_bus.wdata[18:0];
         else if (i_bus.addr == `REG_NUM)
            stage_reg.num <= i_bus.wdata;
         else if (i_bus.addr == `REG_FRAC_DENOMINATOR)
            stage_reg.frac_denominator <= i_bus.wdata;
         else if (i_bus.addr == `REG_MODCFG)
         begin
            stage_reg.order <= i_bus.wdata[1:0];
            stage_reg.dly <= i_bus.wdata[4:2];
            stage_reg.band <= i_bus.wdata[7:5];
            stage_reg.sync_div <= i_bus.wdata[15:8];
            stage_reg.chan_div <= i_bus.wdata[23:16];
            stage_reg.pump <= i_bus.wdata[27:24];
         end
      end
   end

   // ----------------------------------------
   // configuration check
   // ----------------------------------------
   // minimum divide {min_n, delay}; zero marks a range the order may not use
   function automatic logic [8:0] min_rule(input logic [1:0] order, input logic [2:0] band,
                                           input logic sync);
      logic [8:0] r;
      r = 9'h000;
      case (order)
         2'h0: r = (band <= `BAND_12500) ? {6'd29, 3'd1} : {6'd33, 3'd2};
         2'h1:
         begin
            if (band <= `BAND_10000)
               r = {6'd30, 3'd1};
            else if (band == `BAND_12500)
               r = {6'd34, 3'd2};
            else
               r = {6'd38, 3'd3};
         end
         2'h2:
         begin
            if (band == `BAND_4000)
               r = sync ? {6'd31, 3'd1} : 9'h000;
            else if (band == `BAND_7500)
               r = sync ? {6'd31, 3'd2} : 9'h000;
            else if (band == `BAND_10000)
               r = {6'd32, 3'd2};
            else
               r = {6'd36, 3'd3};
         end
         default:
         begin
            if (band == `BAND_4000)
               r = sync ? {6'd33, 3'd1} : 9'h000;
            else if (band == `BAND_7500)
               r = sync ? {6'd37, 3'd2} : 9'h000;
            else if (band == `BAND_10000)
               r = {6'd41, 3'd3};
            else
               r = {6'd45, 3'd4};
         end
      endcase
      return r;
   endfunction : min_rule

   logic [8:0] rule_sel;

   always_comb
   begin
      rule_sel = min_rule(cand.order, cand.band, cand.sync_mode);
      cand_ok = (rule_sel != 9'h000)
         && (cand.band <= `BAND_ABOVE)
         && (cand.n_int >= {13'h0000, rule_sel[8:3]})
         && (cand.n_int >= `N_INT_FLOOR) && (cand.n_int <= `N_INT_MAX)
         && (cand.dly == rule_sel[2:0])
         && (cand.frac_denominator != 32'h00000000)
         && ((cand.order == 2'h0) || (cand.num < cand.frac_denominator))
         && (cand.pre_div != 8'h00) && (cand.pre_div <= `PRE_DIV_MAX)
         && (cand.post_div != 8'h00) && (cand.post_div <= `POST_DIV_MAX)
         && (cand.cal_exp <= `CAL_EXP_MAX)
         && (cand.sync_mode ? (cand.sync_div != 8'h00) : (cand.sync_div == `RST_DIV));
   end

   // a rejected write leaves act_reg untouched, but still clears the modulator and dividers, and a trigger bit still restarts calibration
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         act_reg <= '0;
         act_reg.pre_div <= `RST_DIV;
         act_reg.post_div <= `RST_DIV;
         act_reg.n_int <= `RST_N_INT;
         act_reg.frac_denominator <= `RST_FRAC_DENOMINATOR;
         act_reg.dly <= `RST_DLY;
         act_reg.sync_div <= `RST_DIV;
         act_reg.chan_div <= `RST_DIV;
         act_reg.pump <= `RST_PUMP;
         o_cfg_error <= 1'b0;
         applied_reg <= 1'b0;
         chan_err_reg <= 1'b0;
         pin_function_select_reg <= 1'b0;
      end
      else if (r0_write)
      begin
         pin_function_select_reg <= i_bus.wdata[`CTRL_PIN_SEL];
         o_cfg_error <= !cand_ok;
         applied_reg <= cand_ok;
         // channel divide is software's duty; only reported here
         chan_err_reg <= (cand.chan_div == 8'h00) || (cand.chan_div > `CHAN_DIV_MAX)
            || ((cand.band >= `BAND_12500) && (cand.chan_div > `CHAN_DIV_HIGH_MAX));
         if (cand_ok)
            act_reg <= cand;
      end
   end

   // ----------------------------------------
   // reference path
   // ----------------------------------------
   // doubler counts the falling edge as a second event in the same cycle
   logic [1:0] ref_ticks;
   logic [1:0] pre_ticks;
   logic [1:0] pfd_ticks;

   assign ref_ticks = act_reg.doubler ? 2'h2 : 2'h1;

   tick_divider u_pre_div
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clear(r0_write),
      .i_div(act_reg.pre_div),
      .i_ticks(ref_ticks),
      .o_ticks(pre_ticks)
   );

   tick_divider u_post_div
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clear(r0_write),
      .i_div(act_reg.post_div),
      .i_ticks(pre_ticks),
      .o_ticks(pfd_ticks)
   );

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         pfd_count_reg <= 32'h00000000;
      else
         pfd_count_reg <= pfd_count_reg + {30'h00000000, pfd_ticks};
   end

   // ----------------------------------------
   // phase detector
   // ----------------------------------------
   logic pfd_event;

   assign pfd_event = (pfd_ticks != 2'h0);

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_pump_up <= 1'b0;
         o_pump_dn <= 1'b0;
         o_pump_current <= `RST_PUMP;
      end
      else
      begin
         o_pump_current <= act_reg.pump;
         if ((o_pump_up || pfd_event) && (o_pump_dn || i_fb_pulse))
         begin
            o_pump_up <= 1'b0;
            o_pump_dn <= 1'b0;
         end
         else
         begin
            o_pump_up <= o_pump_up || pfd_event;
            o_pump_dn <= o_pump_dn || i_fb_pulse;
         end
      end
   end

   // ----------------------------------------
   // fractional modulator
   // ----------------------------------------
   // steps once per detector cycle; two edges in one clock advance it only once
   logic [31:0] acc_reg [3];
   logic [31:0] acc_next [3];
   logic [2:0] carry;
   logic [2:0] c3_hist_reg;
   logic c2_hist_reg;
   logic signed [4:0] offset;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_stage
         logic [32:0] sum;
         logic [31:0] feed;
         if (gi == 0)
            assign feed = act_reg.num;
         else
            assign feed = acc_next[gi-1];
         assign sum = {1'b0, acc_reg[gi]} + {1'b0, feed};
         assign carry[gi] = (sum >= {1'b0, act_reg.frac_denominator});
         assign acc_next[gi] = carry[gi]
            ? 32'((sum - {1'b0, act_reg.frac_denominator})) : sum[31:0];
         always_ff @(posedge i_ref_clk)
         begin
            if (!i_rst_n || r0_write)
               acc_reg[gi] <= 32'h00000000;
            else if (pfd_event && (act_reg.order > 2'(gi)))
               acc_reg[gi] <= acc_next[gi];
         end
      end
   endgenerate

   always_comb
   begin
      case (act_reg.order)
         2'h0: offset = 5'sd0;
         2'h1: offset = $signed({4'h0, carry[0]});
         2'h2: offset = $signed({4'h0, carry[0]}) + $signed({4'h0, carry[1]})
            - $signed({4'h0, c2_hist_reg});
         default: offset = $signed({4'h0, carry[0]}) + $signed({4'h0, carry[1]})
            - $signed({4'h0, c2_hist_reg}) + $signed({4'h0, carry[2]})
            - $signed({3'h0, c3_hist_reg[0], 1'b0}) + $signed({4'h0, c3_hist_reg[1]});
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n || r0_write)
      begin
         c2_hist_reg <= 1'b0;
         c3_hist_reg <= 3'h0;
         o_n_strobe <= 1'b0;
         o_n_value <= {1'b0, `RST_N_INT};
      end
      else
      begin
         o_n_strobe <= pfd_event;
         if (pfd_event)
         begin
            c2_hist_reg <= carry[1] && (act_reg.order >= 2'h2);
            c3_hist_reg <= {1'b0, c3_hist_reg[0], carry[2] && (act_reg.order == 2'h3)};
            o_n_value <= 20'(({1'b0, act_reg.n_int}) + 20'(unsigned'(20'(offset))));
         end
      end
   end

   // ----------------------------------------
   // calibration clock and routine
   // ----------------------------------------
   logic [4:0] cal_cnt_reg;
   logic [4:0] cal_mask;
   logic [7:0] cal_steps_reg;

   assign cal_mask = 5'((6'h01 << act_reg.cal_exp) - 6'h01);

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         cal_cnt_reg <= 5'h00;
         o_cal_tick <= 1'b0;
      end
      else
      begin
         cal_cnt_reg <= cal_cnt_reg + 5'h01;
         o_cal_tick <= ((cal_cnt_reg & cal_mask) == cal_mask);
      end
   end

   // the routine is paced by the reference, so a missing reference stalls it
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         cal_state_reg <= synth_pkg::CAL_IDLE;
         cal_steps_reg <= 8'h00;
      end
      else if (r0_write && i_bus.wdata[`CTRL_CAL_TRIG])
      begin
         cal_state_reg <= synth_pkg::CAL_RUN;
         cal_steps_reg <= 8'h00;
      end
      else
      begin
         case (cal_state_reg)
            synth_pkg::CAL_RUN:
            begin
               if (o_cal_tick)
                  cal_steps_reg <= cal_steps_reg + 8'h01;
               if (o_cal_tick && (cal_steps_reg == `CAL_TICKS - 8'h01))
                  cal_state_reg <= synth_pkg::CAL_LOCKED;
            end
            synth_pkg::CAL_LOCKED: cal_state_reg <= synth_pkg::CAL_LOCKED;
            default: cal_state_reg <= synth_pkg::CAL_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // read port and shared pin
   // ----------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_rd_data <= 32'h00000000;
         rb_shift_reg <= 32'h00000000;
         lock_reg <= 1'b0;
         o_shared_output_pin <= 1'b0;
      end
      else
      begin
         lock_reg <= (cal_state_reg == synth_pkg::CAL_LOCKED);
         o_shared_output_pin <= pin_function_select_reg ? lock_reg : rb_shift_reg[31];
         if (i_bus.rd)
         begin
            if (i_bus.addr == `REG_CTRL)
               o_rd_data <= {27'h0000000, act_reg.sync_mode, 1'b0, pin_function_select_reg, 2'h0};
            else if (i_bus.addr == `REG_STATUS)
               o_rd_data <= {27'h0000000, applied_reg, chan_err_reg, o_cfg_error,
                             lock_reg, (cal_state_reg == synth_pkg::CAL_RUN)};
            else if (i_bus.addr == `REG_PFDCNT)
               o_rd_data <= pfd_count_reg;
            else
               o_rd_data <= 32'h00000000;
            rb_shift_reg <= {27'h0000000, applied_reg, chan_err_reg, o_cfg_error,
                             lock_reg, (cal_state_reg == synth_pkg::CAL_RUN)};
         end
         else
            rb_shift_reg <= {rb_shift_reg[30:0], 1'b0};
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence r0_commit_s;
      r0_write ##1 1'b1;
   endsequence

   mod_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      r0_write |=> (acc_reg[0] == 32'h00000000 && !c2_hist_reg))
      else $error("modulator not cleared by control write");

   cal_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (r0_write && i_bus.wdata[`CTRL_CAL_TRIG]) |=> (cal_state_reg == synth_pkg::CAL_RUN))
      else $error("calibration did not start on trigger write");

   keep_config_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (r0_write && !cand_ok) |-> r0_commit_s ##0 ($stable(act_reg) && o_cfg_error))
      else $error("invalid setup was applied or not flagged");

   pin_lock_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      pin_function_select_reg |=> (o_shared_output_pin == $past(lock_reg)))
      else $error("pin does not show lock");

   pin_readback_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !pin_function_select_reg |=> (o_shared_output_pin == $past(rb_shift_reg[31])))
      else $error("pin does not show readback data");

   integer_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (pfd_event && act_reg.order == 2'h0 && !r0_write)
      |=> (o_n_value == {1'b0, $past(act_reg.n_int)}))
      else $error("integer mode produced a fractional divide");

   cal_half_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (act_reg.cal_exp == 3'h1) ##1 (o_cal_tick && act_reg.cal_exp == 3'h1) |=> !o_cal_tick)
      else $error("calibration clock faster than reference over two");

   pump_up_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (pfd_event && !o_pump_dn && !i_fb_pulse) |=> o_pump_up ##0 $stable(o_pump_current))
      else $error("reference edge did not raise the up pump");

endmodule : synth_divider_config

// ===== inc/synth_defs.svh
`ifndef SYNTH_DEFS_SVH
`define SYNTH_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_REFCFG 4'h1
`define REG_NINT 4'h2
`define REG_NUM 4'h3
`define REG_FRAC_DENOMINATOR 4'h4
`define REG_MODCFG 4'h5
`define REG_STATUS 4'h6
`define REG_PFDCNT 4'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_PIN_SEL 2
`define CTRL_CAL_TRIG 3
`define CTRL_SYNC_MODE 4

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define RST_DIV 8'h01
`define RST_N_INT 19'h00064
`define RST_FRAC_DENOMINATOR 32'h00000001
`define RST_DLY 3'h1
`define RST_PUMP 4'h4
`define PRE_DIV_MAX 8'h80
`define POST_DIV_MAX 8'hFF
`define N_INT_MAX 19'h7FFFF
`define N_INT_FLOOR 19'h0001C
`define CHAN_DIV_MAX 8'hC0
`define CHAN_DIV_HIGH_MAX 8'h06
`define CAL_EXP_MAX 3'h5

// ----------------------------------------
// oscillator range codes (vco / sync divide)
// ----------------------------------------
`define BAND_4000 3'h0
`define BAND_7500 3'h1
`define BAND_10000 3'h2
`define BAND_12500 3'h3
`define BAND_ABOVE 3'h4

// ----------------------------------------
// timing counts
// ----------------------------------------
`define CAL_TICKS 8'h40

`endif

// ===== inc/synth_pkg.sv
package synth_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [31:0] wdata;
   } bus_req_type;

   typedef struct packed {
      logic doubler;
      logic [7:0] pre_div;
      logic [7:0] post_div;
      logic [2:0] cal_exp;
      logic [18:0] n_int;
      logic [31:0] num;
      logic [31:0] frac_denominator;
      logic [1:0] order;
      logic [2:0] dly;
      logic [2:0] band;
      logic [7:0] sync_div;
      logic sync_mode;
      logic [7:0] chan_div;
      logic [3:0] pump;
   } cfg_type;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_RUN = 3'b010,
      CAL_LOCKED = 3'b100
   } cal_state_type;

endpackage : synth_pkg

// ===== hw/tick_divider.sv
`timescale 1ns/1ns
`include "synth_defs.svh"

module tick_divider
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_clear,
   input wire logic [7:0] i_div,
   // edge counts, 0 to 2 per cycle
   input wire logic [1:0] i_ticks,
   output logic [1:0] o_ticks
);

   logic [7:0] acc_reg;
   logic [8:0] sum;
   logic [8:0] div_x1;
   logic [8:0] div_x2;

   assign sum = {1'b0, acc_reg} + {7'h00, i_ticks};
   assign div_x1 = {1'b0, i_div};
   assign div_x2 = {i_div, 1'b0};

   // a divide of 1 bypasses residue counting and passes both doubled edges straight on
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n || i_clear)
      begin
         acc_reg <= 8'h00;
         o_ticks <= 2'h0;
      end
      else if (i_div <= `RST_DIV)
      begin
         acc_reg <= 8'h00;
         o_ticks <= i_ticks;
      end
      else if (sum >= div_x2)
      begin
         acc_reg <= 8'((sum - div_x2));
         o_ticks <= 2'h2;
      end
      else if (sum >= div_x1)
      begin
         acc_reg <= 8'((sum - div_x1));
         o_ticks <= 2'h1;
      end
      else
      begin
         acc_reg <= sum[7:0];
         o_ticks <= 2'h0;
      end
   end

   bypass_pass_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_div == 8'h01 && !i_clear) |=> (o_ticks == $past(i_ticks)))
      else $error("divide of one did not pass edges through");

   no_gain_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_div > 8'h02 && !i_clear && $stable(i_div)) |=> (o_ticks < 2'h2))
      else $error("divider above two emitted two edges in one cycle");

endmodule : tick_divider

// ===== dv/synth_divider_config_tb.sv
`timescale 1ns/1ns

module synth_divider_config_tb;
   // ----------
   // signals
   // ----------
   logic i_ref_clk;
   logic i_rst_n;
   synth_pkg::bus_req_type i_bus;
   logic i_fb_pulse;
   logic [31:0] o_rd_data;
   logic [3:0] o_pump_current;
   logic [19:0] o_n_value;
   logic o_pump_up, o_pump_dn, o_n_strobe, o_cal_tick, o_shared_output_pin, o_cfg_error;
   int n_errors = 0;
   int n_tests = 0;
   int k, g;
   logic [31:0] rd, s, d1;
   logic [3:0] pump_exp;
   logic [21:0] sum;
   typedef struct {logic [31:0] rf; int n, num, frac_denominator;
      logic [31:0] md; int ct, err;} row_type;
   row_type rows [16];
   logic [31:0] refs [5];
   int gaps [5] = '{1, 4, 2, 6, 3};
   int cx [3] = '{0, 1, 2};

   synth_divider_config dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_bus(i_bus),
      .o_rd_data(o_rd_data), .i_fb_pulse(i_fb_pulse), .o_pump_up(o_pump_up),
      .o_pump_dn(o_pump_dn), .o_pump_current(o_pump_current), .o_n_strobe(o_n_strobe),
      .o_n_value(o_n_value), .o_cal_tick(o_cal_tick),
      .o_shared_output_pin(o_shared_output_pin), .o_cfg_error(o_cfg_error));

   // reference runs from time zero, so it is present before any trigger write
   initial
   begin
      i_ref_clk = 1'h0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end

   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] rc(int d, int pr, int po, int x);
      return {5'h0, x[2:0], po[7:0], pr[7:0], 7'h0, d[0]};
   endfunction : rc

   // channel divide held at one, inside its limits
   function automatic logic [31:0] mc(int o, int dl, int b, int sd, int p);
      return {4'h0, p[3:0], 8'h01, sd[7:0], b[2:0], dl[2:0], o[1:0]};
   endfunction : mc

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      n_tests++;
      if (v !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, v);
      end
   endtask : chk

   task automatic results();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      i_bus <= '{1'h1, 1'h0, a, d};
      @(posedge i_ref_clk);
      i_bus <= '0;
      @(posedge i_ref_clk);
   endtask : wr

   // every read reloads the pin shifter, so the serial word is captured each time
   task automatic rdt(input logic [3:0] a);
      i_bus <= '{1'h0, 1'h1, a, 32'h0};
      @(posedge i_ref_clk);
      i_bus <= '0;
      #1 rd = o_rd_data;
      repeat (32)
      begin
         @(posedge i_ref_clk);
         #1 s = {s[30:0], o_shared_output_pin};
      end
      @(posedge i_ref_clk);
   endtask : rdt

   task automatic wstb(input int lim);
      k = 0;
      do
      begin
         @(posedge i_ref_clk);
         #1 k = k + 1;
      end
      while (o_n_strobe !== 1'h1 && k < lim);
      chk("strobe_wait", 32'h1, {31'h0, k < lim});
   endtask : wstb

   task automatic fb();
      @(posedge i_ref_clk);
      i_fb_pulse <= 1'h1;
      @(posedge i_ref_clk);
      i_fb_pulse <= 1'h0;
      repeat (3) @(posedge i_ref_clk);
      #1;
   endtask : fb

   task automatic rst();
      i_rst_n <= 1'h0;
      repeat (10) @(posedge i_ref_clk);
      i_rst_n <= 1'h1;
      @(posedge i_ref_clk);
      #1;
      chk("pump_current", 32'h4, {28'h0, o_pump_current});
      chk("n_value", 32'h64, {12'h0, o_n_value});
      chk("rd_data", 32'h0, o_rd_data);
      chk("flags", 32'h0, {27'h0, o_pump_up, o_pump_dn, o_n_strobe, o_cfg_error,
         o_shared_output_pin});
      @(posedge i_ref_clk);
   endtask : rst

   // ----------
   // sequence
   // ----------
   initial
   begin
      i_bus = '0;
      i_fb_pulse = 1'h0;
      i_rst_n = 1'h0;
      pump_exp = 4'h4;
      d1 = rc(0, 1, 1, 0);
      refs = '{rc(0, 1, 1, 0), rc(0, 4, 1, 0), rc(1, 4, 1, 0), rc(0, 2, 3, 0), rc(1, 2, 3, 0)};
      rows = '{
         '{d1, 29, 0, 1, mc(0, 1, 0, 1, 5), 0, 0},
         '{d1, 28, 0, 1, mc(0, 1, 0, 1, 6), 0, 1},
         '{d1, 33, 0, 1, mc(0, 2, 4, 1, 7), 0, 0},
         '{d1, 33, 0, 1, mc(0, 1, 4, 1, 8), 0, 1},
         '{d1, 34, 1, 3, mc(1, 2, 3, 1, 9), 0, 0},
         '{d1, 34, 3, 3, mc(1, 2, 3, 1, 6), 0, 1},
         '{d1, 31, 1, 3, mc(2, 1, 0, 1, 7), 0, 1},
         '{d1, 31, 1, 3, mc(2, 2, 1, 2, 10), 16, 0},
         '{d1, 32, 1, 3, mc(2, 2, 2, 2, 8), 0, 1},
         '{d1, 36, 1, 3, mc(2, 3, 4, 1, 11), 0, 0},
         '{d1, 33, 1, 3, mc(3, 1, 0, 1, 12), 16, 0},
         '{d1, 44, 1, 3, mc(3, 4, 4, 1, 9), 0, 1},
         '{d1, 41, 1, 3, mc(3, 3, 2, 1, 13), 0, 0},
         '{rc(0, 128, 255, 5), 524287, 0, -1, mc(0, 1, 0, 1, 3), 0, 0},
         '{rc(0, 129, 1, 0), 29, 0, 1, mc(0, 1, 0, 1, 9), 0, 1},
         '{d1, 29, 0, 0, mc(0, 1, 0, 1, 9), 0, 1}
      };
      rst();
      foreach (rows[i])
      begin
         wr(4'h1, rows[i].rf);
         wr(4'h2, rows[i].n);
         wr(4'h3, rows[i].num);
         wr(4'h4, rows[i].frac_denominator);
         wr(4'h5, rows[i].md);
         wr(4'h0, rows[i].ct);
         if (rows[i].err == 0)
            pump_exp = rows[i].md[27:24];
         #1;
         chk("cfg_error", rows[i].err, {31'h0, o_cfg_error});
         chk("pump_current", {28'h0, pump_exp}, {28'h0, o_pump_current});
         @(posedge i_ref_clk);
      end
      // first order, one third: values 30, 30, 31 from a cleared modulator
      wr(4'h2, 32'h1E);
      wr(4'h3, 32'h1);
      wr(4'h4, 32'h3);
      wr(4'h5, mc(1, 1, 2, 1, 4));
      foreach (refs[i])
      begin
         wr(4'h1, refs[i]);
         wr(4'h0, 32'h0);
         sum = '0;
         for (int j = 0; j < 3; j++)
         begin
            wstb(60);
            if (i == 0 && j == 0)
               chk("latency", 32'h2, k);
            if (j == 0)
               chk("first_value", 32'h1E, {12'h0, o_n_value});
            sum = sum + o_n_value;
         end
         chk("strobe_gap", gaps[i], k);
         chk("value_sum", 32'h5B, {10'h0, sum});
         @(posedge i_ref_clk);
      end
      // slow reference leaves room to pulse feedback between detector edges
      wr(4'h1, rc(0, 16, 16, 0));
      wr(4'h0, 32'h0);
      wstb(400);
      chk("pump_up", 32'h1, {31'h0, o_pump_up});
      fb();
      chk("pump_pair", 32'h0, {30'h0, o_pump_up, o_pump_dn});
      fb();
      chk("pump_pair", 32'h1, {30'h0, o_pump_up, o_pump_dn});
      wstb(300);
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk("pump_pair", 32'h0, {30'h0, o_pump_up, o_pump_dn});
      @(posedge i_ref_clk);
      // the first cycles are skipped: the pin may still show the previous lock
      foreach (cx[i])
      begin
         wr(4'h1, rc(0, 1, 1, cx[i]));
         // apply the new rate first, so a tick of the old rate cannot pace the first step
         wr(4'h0, 32'h4);
         wr(4'h0, 32'hC);
         k = 0;
         g = 0;
         while ((o_shared_output_pin !== 1'h1 || k < 8) && k < 600)
         begin
            @(posedge i_ref_clk);
            #1 k = k + 1;
            if (k > 10 && k <= 50)
               g = g + o_cal_tick;
         end
         chk("cal_ticks", 40 >> cx[i], g);
         chk("lock_time", 32'h1, {31'h0, k >= (64 << cx[i]) - 4 && k <= (64 << cx[i]) + 8});
         @(posedge i_ref_clk);
      end
      rdt(4'h0);
      chk("ctrl", 32'h4, rd);
      wr(4'h0, 32'h0);
      rdt(4'h6);
      chk("status", 32'h2, rd & 32'hFFFF_FFEF);
      chk("pin_serial", 32'h2, s & 32'hFFFF_FFEF);
      wr(4'h6, 32'hFFFF_FFFF);
      rdt(4'h6);
      chk("status", 32'h2, rd & 32'hFFFF_FFEF);
      rdt(4'h9);
      chk("unmapped", 32'h0, rd);
      chk("pin_serial", 32'h2, s & 32'hFFFF_FFEF);
      rdt(4'h1);
      chk("write_only", 32'h0, rd);
      rst();
      results();
   end

   initial
   begin
      #400000;
      chk("watchdog", 32'h0, 32'h1);
      results();
   end
endmodule : synth_divider_config_tb
